// ### rtl/hub_cfg_pkg.sv
/*
  constants, encodings and state types shared by both ends of the hub
  configuration register link.
  assumes a single 40 MHz clock and one byte-wide register space.
*/
package hub_cfg_pkg;
  // register map of the device
  localparam logic [7:0] MAKER_TEXT_BASE = 8'h50;
  localparam logic [7:0] MAKER_TEXT_TOP = 8'h8f;
  localparam logic [7:0] PRODUCT_TEXT_BASE = 8'h90;
  localparam logic [7:0] PRODUCT_TEXT_TOP = 8'hcf;
  localparam logic [7:0] FEATURE_ADDR = 8'hf0;
  localparam logic [7:0] STATUS_ADDR = 8'hf8;
  localparam logic [7:0] FEATURE_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] TEXT_RESET = 8'h00;
  localparam logic [7:0] FEATURE_RSVD_MASK = 8'he0;
  localparam int TEXT_BYTES = 128;
  localparam logic [6:0] TEXT_HALF = 7'h40;
  localparam logic [6:0] TEXT_MAX_LEN = 7'h40;
  // feature and status field positions
  localparam int FEAT_LINK_IND_BIT = 4;
  localparam int FEAT_DELAY_LSB = 1;
  localparam int FEAT_SPREAD_BIT = 0;
  localparam int STAT_SOFT_RST_BIT = 1;
  localparam int STAT_CFG_BIT = 0;
  // string indices
  localparam logic [7:0] MAKER_TEXT_INDEX = 8'h03;
  localparam logic [7:0] PRODUCT_TEXT_INDEX = 8'h02;
  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int DELAY_STEP_MS = 200;
  localparam int DELAY_STEP_CYCLES = CLK_HZ / 1000 * DELAY_STEP_MS;
  localparam int WAIT_W = 26;
  // host-side user registers
  localparam logic [2:0] HOST_TARGET_ADDR = 3'h0;
  localparam logic [2:0] HOST_WDATA_ADDR = 3'h1;
  localparam logic [2:0] HOST_CMD_ADDR = 3'h2;
  localparam logic [2:0] HOST_RDATA_ADDR = 3'h3;
  localparam logic [2:0] HOST_STATUS_ADDR = 3'h4;
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_READ_BIT = 1;
  localparam int CMD_RELEASE_BIT = 2;
  localparam logic [7:0] CFG_RELEASE_VALUE = 8'h01;

  typedef enum logic [2:0] {
    DEV_IDLE = 3'b001,
    DEV_SEND = 3'b010,
    DEV_RELOAD = 3'b100
  } dev_fsm_t;

  typedef enum logic [2:0] {
    HOST_IDLE = 3'b001,
    HOST_ISSUE = 3'b010,
    HOST_CAPTURE = 3'b100
  } host_fsm_t;
endpackage : hub_cfg_pkg

// ### rtl/hub_cfg_if.sv
/*
  byte-wide register link between the configuration host and the hub.
  assumes both ends share one clock; read data follow a read strobe by one cycle.
*/
`timescale 1ns/10ps
interface hub_cfg_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;

  modport dev (
    input addr,
    input wdata,
    input wr,
    input rd,
    output rdata
  );

  modport host (
    output addr,
    output wdata,
    output wr,
    output rd,
    input rdata
  );
endinterface : hub_cfg_if

// ### rtl/hub_cfg_regs.sv
/*
  hub configuration register bank: maker and product text arrays, feature
  register, status and command register, descriptor byte streamer and
  port power restore timer.
  assumes all inputs synchronous to i_clk and at most one request per source
  per cycle.
*/
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
module hub_cfg_regs #(
  parameter int DELAY_STEP = hub_cfg_pkg::DELAY_STEP_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // register link
  hub_cfg_if.dev link,
  // eeprom loader writes
  input wire logic i_ee_wr,
  input wire logic [7:0] i_ee_addr,
  input wire logic [7:0] i_ee_data,
  // mode and fuses
  input wire logic i_smbus_mode,
  input wire logic i_i2c_mode,
  input wire logic [2:0] i_fused_power_restore_delay,
  input wire logic [6:0] i_maker_text_length,
  input wire logic [6:0] i_product_text_length,
  // descriptor requests
  input wire logic i_desc_req,
  input wire logic [7:0] i_desc_index,
  output logic o_desc_valid,
  output logic [7:0] o_desc_byte,
  output logic o_desc_last,
  output logic o_desc_none,
  // link status sources
  input wire logic i_highspeed_link_up,
  input wire logic i_highspeed_suspended,
  input wire logic i_superspeed_link_up,
  input wire logic i_superspeed_suspended,
  // status and control outputs, charge mode change input
  output logic o_highspeed_link_up_out,
  output logic o_highspeed_suspended_out,
  output logic o_superspeed_link_up_out,
  output logic o_superspeed_suspended_out,
  output logic o_pll_spread_disable,
  input wire logic i_charge_mode_change,
  output logic o_port_power_switch_enable,
  output logic o_upstream_connect_allow
);
  typedef struct packed {
    logic [hub_cfg_pkg::TEXT_BYTES-1:0][7:0] text;
    logic [7:0] feature;
    logic soft_rst;
    logic cfg_active;
    logic smbus_q;
    logic i2c_q;
    hub_cfg_pkg::dev_fsm_t fsm;
    logic [6:0] ptr;
    logic [6:0] remain;
    logic [7:0] rdata;
    logic desc_valid;
    logic [7:0] desc_byte;
    logic desc_last;
    logic desc_none;
    logic [3:0] ind;
    logic spread_dis;
    logic [hub_cfg_pkg::WAIT_W-1:0] wait_cnt;
    logic pwr_en;
  } dev_state_t;

  localparam logic [hub_cfg_pkg::WAIT_W-1:0] STEP = hub_cfg_pkg::WAIT_W'(DELAY_STEP);
  localparam logic [hub_cfg_pkg::WAIT_W-1:0] ONE = hub_cfg_pkg::WAIT_W'(1);

  dev_state_t state_ff;
  dev_state_t nxt_state;

  // configuration write into text or feature; status is handled by the link only
  function automatic dev_state_t cfg_write(dev_state_t s, logic [7:0] a, logic [7:0] d);
    dev_state_t r;
    r = s;
    if (a >= hub_cfg_pkg::MAKER_TEXT_BASE && a <= hub_cfg_pkg::PRODUCT_TEXT_TOP) begin
      r.text[7'(a - hub_cfg_pkg::MAKER_TEXT_BASE)] = d;
    end else if (a == hub_cfg_pkg::FEATURE_ADDR) begin
      r.feature = d;
    end
    return r;
  endfunction : cfg_write

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [6:0] len;
    logic [2:0] delay;
    logic cfg_set;
    logic cfg_clr;
    len = '0;
    delay = '0;
    cfg_set = 1'b0;
    cfg_clr = 1'b0;
    nxt_state = state_ff;
    nxt_state.smbus_q = i_smbus_mode;
    nxt_state.i2c_q = i_i2c_mode;
    nxt_state.desc_valid = 1'b0;
    nxt_state.desc_last = 1'b0;
    nxt_state.desc_none = 1'b0;

    // link read, one cycle later
    nxt_state.rdata = 8'h00;
    if (link.rd) begin
      if (link.addr >= hub_cfg_pkg::MAKER_TEXT_BASE &&
          link.addr <= hub_cfg_pkg::PRODUCT_TEXT_TOP) begin
        nxt_state.rdata = state_ff.text[7'(link.addr - hub_cfg_pkg::MAKER_TEXT_BASE)];
      end else if (link.addr == hub_cfg_pkg::FEATURE_ADDR) begin
        nxt_state.rdata = state_ff.feature;
      end else if (link.addr == hub_cfg_pkg::STATUS_ADDR) begin
        nxt_state.rdata[hub_cfg_pkg::STAT_SOFT_RST_BIT] = state_ff.soft_rst;
        nxt_state.rdata[hub_cfg_pkg::STAT_CFG_BIT] = state_ff.cfg_active;
      end
    end

    // eeprom first so a host write in the same cycle overwrites it
    if (i_ee_wr) begin
      nxt_state = cfg_write(nxt_state, i_ee_addr, i_ee_data);
    end
    if (link.wr) begin
      nxt_state = cfg_write(nxt_state, link.addr, link.wdata);
      if (link.addr == hub_cfg_pkg::STATUS_ADDR) begin
        cfg_clr = link.wdata[hub_cfg_pkg::STAT_CFG_BIT];
        if (link.wdata[hub_cfg_pkg::STAT_SOFT_RST_BIT] && i_smbus_mode) begin
          nxt_state.soft_rst = 1'b1;
          nxt_state.fsm = hub_cfg_pkg::DEV_RELOAD;
        end
      end
    end

    // configuration flag: hardware set wins over any clear
    if (i_i2c_mode == 1'b0 && state_ff.i2c_q) begin
      cfg_clr = 1'b1;
    end
    if ((i_smbus_mode && !state_ff.smbus_q) || (i_i2c_mode && !state_ff.i2c_q)) begin
      cfg_set = 1'b1;
    end
    if (cfg_clr) begin
      nxt_state.cfg_active = 1'b0;
    end
    if (cfg_set) begin
      nxt_state.cfg_active = 1'b1;
    end

    // descriptor streamer and soft reload
    case (state_ff.fsm)
      hub_cfg_pkg::DEV_IDLE: begin
        if (i_desc_req) begin
          if (i_desc_index == hub_cfg_pkg::MAKER_TEXT_INDEX) begin
            len = i_maker_text_length;
            nxt_state.ptr = 7'h00;
          end else if (i_desc_index == hub_cfg_pkg::PRODUCT_TEXT_INDEX) begin
            len = i_product_text_length;
            nxt_state.ptr = hub_cfg_pkg::TEXT_HALF;
          end
          if (len > hub_cfg_pkg::TEXT_MAX_LEN) begin
            len = hub_cfg_pkg::TEXT_MAX_LEN;
          end
          if (len == 7'h00) begin
            nxt_state.desc_none = 1'b1;
          end else if (nxt_state.fsm == hub_cfg_pkg::DEV_IDLE) begin
            nxt_state.remain = len;
            nxt_state.fsm = hub_cfg_pkg::DEV_SEND;
          end
        end
      end
      hub_cfg_pkg::DEV_SEND: begin
        if (nxt_state.fsm != hub_cfg_pkg::DEV_RELOAD) begin
          nxt_state.desc_valid = 1'b1;
          nxt_state.desc_byte = state_ff.text[state_ff.ptr];
          nxt_state.ptr = state_ff.ptr + 7'h01;
          nxt_state.remain = state_ff.remain - 7'h01;
          if (state_ff.remain == 7'h01) begin
            nxt_state.desc_last = 1'b1;
            nxt_state.fsm = hub_cfg_pkg::DEV_IDLE;
          end
        end
      end
      hub_cfg_pkg::DEV_RELOAD: begin
        for (int i = 0; i < hub_cfg_pkg::TEXT_BYTES; i++) begin
          nxt_state.text[i] = hub_cfg_pkg::TEXT_RESET;
        end
        nxt_state.feature = hub_cfg_pkg::FEATURE_RESET;
        nxt_state.cfg_active = 1'b1;
        nxt_state.soft_rst = 1'b0;
        nxt_state.fsm = hub_cfg_pkg::DEV_IDLE;
      end
      default: begin
        nxt_state.fsm = hub_cfg_pkg::DEV_IDLE;
      end
    endcase

    // indicators and pll follow the stored feature byte
    nxt_state.ind = {4{state_ff.feature[hub_cfg_pkg::FEAT_LINK_IND_BIT]}} &
                    {i_highspeed_link_up, i_highspeed_suspended,
                     i_superspeed_link_up, i_superspeed_suspended};
    nxt_state.spread_dis = state_ff.feature[hub_cfg_pkg::FEAT_SPREAD_BIT];

    // power restore: fused value wins when nonzero
    delay = state_ff.feature[hub_cfg_pkg::FEAT_DELAY_LSB +: 3];
    if (i_fused_power_restore_delay != 3'b000) begin
      delay = i_fused_power_restore_delay;
    end
    if (i_charge_mode_change) begin
      nxt_state.pwr_en = 1'b0;
      nxt_state.wait_cnt = hub_cfg_pkg::WAIT_W'(STEP * delay);
      if (delay == 3'b000) begin
        nxt_state.wait_cnt = ONE;
      end
    end else if (state_ff.wait_cnt != '0) begin
      nxt_state.wait_cnt = state_ff.wait_cnt - ONE;
      if (state_ff.wait_cnt == ONE) begin
        nxt_state.pwr_en = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff <= '0;
      state_ff.fsm <= hub_cfg_pkg::DEV_IDLE;
      state_ff.pwr_en <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign link.rdata = state_ff.rdata;
  assign o_desc_valid = state_ff.desc_valid;
  assign o_desc_byte = state_ff.desc_byte;
  assign o_desc_last = state_ff.desc_last;
  assign o_desc_none = state_ff.desc_none;
  assign o_highspeed_link_up_out = state_ff.ind[3];
  assign o_highspeed_suspended_out = state_ff.ind[2];
  assign o_superspeed_link_up_out = state_ff.ind[1];
  assign o_superspeed_suspended_out = state_ff.ind[0];
  assign o_pll_spread_disable = state_ff.spread_dis;
  assign o_port_power_switch_enable = state_ff.pwr_en;
  assign o_upstream_connect_allow = !state_ff.cfg_active;
endmodule : hub_cfg_regs

// ### rtl/hub_cfg_host.sv
/*
  configuration host end: software-facing command registers that turn into
  single strobes on the hub register link.
  assumes the device answers a read strobe with data in the next cycle.
*/
`timescale 1ns/10ps
module hub_cfg_host (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // software port
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // register link
  hub_cfg_if.host link
);
  typedef struct packed {
    hub_cfg_pkg::host_fsm_t fsm;
    logic [7:0] target;
    logic [7:0] wdata;
    logic [7:0] captured;
    logic done;
    logic [7:0] l_addr;
    logic [7:0] l_wdata;
    logic l_wr;
    logic l_rd;
    logic [7:0] rdata;
  } host_state_t;

  host_state_t state_ff;
  host_state_t nxt_state;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic busy;
    busy = state_ff.fsm != hub_cfg_pkg::HOST_IDLE;
    nxt_state = state_ff;
    nxt_state.rdata = 8'h00;
    nxt_state.l_wr = 1'b0;
    nxt_state.l_rd = 1'b0;

    if (i_rd) begin
      case (i_addr)
        hub_cfg_pkg::HOST_TARGET_ADDR: nxt_state.rdata = state_ff.target;
        hub_cfg_pkg::HOST_WDATA_ADDR: nxt_state.rdata = state_ff.wdata;
        hub_cfg_pkg::HOST_RDATA_ADDR: nxt_state.rdata = state_ff.captured;
        hub_cfg_pkg::HOST_STATUS_ADDR: nxt_state.rdata = {6'b00_0000, state_ff.done, busy};
        default: nxt_state.rdata = 8'h00;
      endcase
    end

    if (i_wr && i_addr == hub_cfg_pkg::HOST_TARGET_ADDR) begin
      nxt_state.target = i_wdata;
    end
    if (i_wr && i_addr == hub_cfg_pkg::HOST_WDATA_ADDR) begin
      nxt_state.wdata = i_wdata;
    end

    case (state_ff.fsm)
      hub_cfg_pkg::HOST_IDLE: begin
        // commands while busy are dropped; software polls the done bit
        if (i_wr && i_addr == hub_cfg_pkg::HOST_CMD_ADDR) begin
          nxt_state.done = 1'b0;
          nxt_state.l_addr = nxt_state.target;
          nxt_state.l_wdata = nxt_state.wdata;
          if (nxt_state.target == hub_cfg_pkg::FEATURE_ADDR) begin
            nxt_state.l_wdata = nxt_state.wdata & ~hub_cfg_pkg::FEATURE_RSVD_MASK;
          end
          if (i_wdata[hub_cfg_pkg::CMD_RELEASE_BIT]) begin
            nxt_state.l_addr = hub_cfg_pkg::STATUS_ADDR;
            nxt_state.l_wdata = hub_cfg_pkg::CFG_RELEASE_VALUE;
            nxt_state.l_wr = 1'b1;
          end else if (i_wdata[hub_cfg_pkg::CMD_WRITE_BIT]) begin
            nxt_state.l_wr = 1'b1;
          end else if (i_wdata[hub_cfg_pkg::CMD_READ_BIT]) begin
            nxt_state.l_rd = 1'b1;
          end
          if (nxt_state.l_wr || nxt_state.l_rd) begin
            nxt_state.fsm = hub_cfg_pkg::HOST_ISSUE;
          end
        end
      end
      hub_cfg_pkg::HOST_ISSUE: begin
        if (state_ff.l_rd) begin
          nxt_state.fsm = hub_cfg_pkg::HOST_CAPTURE;
        end else begin
          nxt_state.done = 1'b1;
          nxt_state.fsm = hub_cfg_pkg::HOST_IDLE;
        end
      end
      hub_cfg_pkg::HOST_CAPTURE: begin
        nxt_state.captured = link.rdata;
        nxt_state.done = 1'b1;
        nxt_state.fsm = hub_cfg_pkg::HOST_IDLE;
      end
      default: begin
        nxt_state.fsm = hub_cfg_pkg::HOST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff <= '0;
      state_ff.fsm <= hub_cfg_pkg::HOST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_rdata = state_ff.rdata;
  assign link.addr = state_ff.l_addr;
  assign link.wdata = state_ff.l_wdata;
  assign link.wr = state_ff.l_wr;
  assign link.rd = state_ff.l_rd;
endmodule : hub_cfg_host

// ### dv/hub_cfg_chk.sv
/*
  assertions on the hub configuration register link.
  assumes one clock and a host that spaces its single strobes apart.
*/
`timescale 1ns/10ps
module hub_cfg_chk (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // link signals
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata
);
  logic [7:0] lw_addr_ff;
  logic [7:0] lw_data_ff;
  logic lw_ok_ff;
  logic is_text;
  logic is_map;
  assign is_text = addr >= 8'h50 && addr <= 8'hcf;
  assign is_map = is_text || addr == 8'hf0;

  ////////////////////////////////////////////////////////////////////////////
  // last host write; eeprom loads are invisible here, so a soft reset drops it
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lw_ok_ff <= 1'b0;
      lw_addr_ff <= 8'h00;
      lw_data_ff <= 8'h00;
    end else if (wr && is_map) begin
      lw_ok_ff <= 1'b1;
      lw_addr_ff <= addr;
      lw_data_ff <= wdata;
    end else if (wr && addr == 8'hf8 && wdata[1]) begin
      lw_ok_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  rdata_idle_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !rd |=> rdata == 8'h00) else $error("read data outside a read answer");
  unmapped_zero_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    rd && !is_map && addr != 8'hf8 |=> rdata == 8'h00) else $error("unmapped read not zero");
  status_rsvd_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    rd && addr == 8'hf8 |=> rdata[7:2] == 6'h00) else $error("status reserved bits set");
  srst_selfclr_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    rd && addr == 8'hf8 |=> !rdata[1]) else $error("soft reset bit stuck");
  feat_rsvd_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    wr && addr == 8'hf0 |-> wdata[7:5] == 3'b000) else $error("feature upper bits written");
  text_back_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    rd && is_text && lw_ok_ff && addr == lw_addr_ff |=> rdata == $past(lw_data_ff))
    else $error("text byte readback wrong");
  feat_back_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    rd && addr == 8'hf0 && lw_ok_ff && lw_addr_ff == 8'hf0 |=> rdata == $past(lw_data_ff))
    else $error("feature readback wrong");
  strobe_one_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    wr || rd |-> !(wr && rd) ##1 !wr && !rd) else $error("strobe not a single pulse");
endmodule : hub_cfg_chk

// ### dv/hub_string_and_smbus_config_regs_bench.sv
/*
  self-checking bench: host end and device end joined by the link.
  assumes DELAY_STEP of 4 cycles; bench model holds expected register bytes.
*/
`timescale 1ns/10ps
module hub_string_and_smbus_config_regs_bench;
  logic clk = 1'b0, arst_n = 1'b0, sw_wr = 1'b0, sw_rd = 1'b0, ee_wr = 1'b0;
  logic smbus = 1'b0, i2c = 1'b0, dreq = 1'b0, chg = 1'b0;
  logic dvalid, dlast, dnone, spread, pwr_en, up_ok;
  logic [2:0] sw_addr = 3'h0, fuse = 3'h0;
  logic [7:0] sw_wdata = 8'h00, ee_addr = 8'h00, ee_data = 8'h00, didx = 8'h00;
  logic [6:0] mlen = 7'h00, plen = 7'h00;
  logic [3:0] lnk = 4'h0;
  logic [3:0] ind;
  logic [7:0] sw_rdata, dbyte, d, v;
  logic [7:0] mem [256];
  logic [31:0] rnd = 32'h0000_48fc;
  int n_mismatch = 0;
  int samples_checked = 0;

  always #12.5 clk = ~clk;
  hub_cfg_if hub_cfg_if_inst ();
  hub_cfg_regs #(.DELAY_STEP(4)) hub_cfg_regs_inst (.i_clk(clk), .i_arst_n(arst_n),
    .link(hub_cfg_if_inst.dev), .i_ee_wr(ee_wr), .i_ee_addr(ee_addr), .i_ee_data(ee_data),
    .i_smbus_mode(smbus), .i_i2c_mode(i2c), .i_fused_power_restore_delay(fuse),
    .i_maker_text_length(mlen), .i_product_text_length(plen), .i_desc_req(dreq),
    .i_desc_index(didx), .o_desc_valid(dvalid), .o_desc_byte(dbyte), .o_desc_last(dlast),
    .o_desc_none(dnone), .i_highspeed_link_up(lnk[3]), .i_highspeed_suspended(lnk[2]),
    .i_superspeed_link_up(lnk[1]), .i_superspeed_suspended(lnk[0]),
    .o_highspeed_link_up_out(ind[3]), .o_highspeed_suspended_out(ind[2]),
    .o_superspeed_link_up_out(ind[1]), .o_superspeed_suspended_out(ind[0]),
    .o_pll_spread_disable(spread), .i_charge_mode_change(chg),
    .o_port_power_switch_enable(pwr_en), .o_upstream_connect_allow(up_ok));
  hub_cfg_host hub_cfg_host_inst (.i_clk(clk), .i_arst_n(arst_n), .i_addr(sw_addr),
    .i_wdata(sw_wdata), .i_wr(sw_wr), .i_rd(sw_rd), .o_rdata(sw_rdata),
    .link(hub_cfg_if_inst.host));
  hub_cfg_chk hub_cfg_chk_inst (.i_clk(clk), .i_arst_n(arst_n), .addr(hub_cfg_if_inst.addr),
    .wdata(hub_cfg_if_inst.wdata), .wr(hub_cfg_if_inst.wr), .rd(hub_cfg_if_inst.rd),
    .rdata(hub_cfg_if_inst.rdata));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8
  task automatic chk_cnt(input string nm, input int e, input int g);
    samples_checked++;
    if (g != e) begin
      n_mismatch++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_cnt
  task automatic sw_write(input logic [2:0] a, input logic [7:0] x);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= x;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask : sw_write
  task automatic sw_read(input logic [2:0] a, output logic [7:0] x);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 x = sw_rdata;
  endtask : sw_read
  // poll done, bounded so a dead host cannot hang the run
  task automatic link_op(input logic [7:0] a, input logic [7:0] x, input logic [2:0] cmd);
    logic [7:0] s;
    sw_write(3'h0, a);
    sw_write(3'h1, x);
    sw_write(3'h2, {5'h00, cmd});
    s = 8'h00;
    for (int k = 0; k < 16 && s[1] !== 1'b1; k++) sw_read(3'h4, s);
    chk8("host done", 8'h02, s & 8'h02);
  endtask : link_op
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] x);
    link_op(a, x, 3'b001);
    mem[a] = (a == 8'hf0) ? (x & 8'h1f) : x;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    link_op(a, 8'h00, 3'b010);
    sw_read(3'h3, d);
    chk8($sformatf("register %h", a), e, d);
  endtask : rd_reg
  task automatic desc(input logic [7:0] idx, input logic [6:0] len);
    int n;
    int e;
    logic [7:0] b;
    e = (idx == 8'h02 || idx == 8'h03) ? ((len > 7'd64) ? 64 : int'(len)) : 0;
    b = (idx == 8'h03) ? 8'h50 : 8'h90;
    n = 0;
    @(posedge clk);
    mlen <= len;
    plen <= len;
    didx <= idx;
    dreq <= 1'b1;
    @(posedge clk);
    dreq <= 1'b0;
    for (int k = 0; k < 80; k++) begin
      #1;
      if (dvalid === 1'b1) begin
        chk8("descriptor byte", mem[b + n], dbyte);
        chk8("descriptor last", {7'h00, n == e - 1}, {7'h00, dlast});
        n++;
      end
      if (dlast === 1'b1 || dnone === 1'b1) break;
      @(posedge clk);
    end
    chk_cnt("descriptor length", e, n);
    chk8("descriptor none", {7'h00, e == 0}, {7'h00, dnone});
  endtask : desc
  task automatic power(input logic [2:0] fz, input int e);
    int n;
    n = 0;
    @(posedge clk);
    fuse <= fz;
    chg <= 1'b1;
    @(posedge clk);
    chg <= 1'b0;
    for (int k = 0; k < 60; k++) begin
      #1 n += (pwr_en === 1'b0);
      @(posedge clk);
    end
    chk_cnt("power off span", e, n);
  endtask : power
  task automatic complete_run;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    foreach (mem[i]) if (i % 37 == 0 || i >= 8'hf0) rd_reg(i[7:0], 8'h00);
    chk8("power enable", 8'h01, {7'h00, pwr_en});
    chk8("connect allow", 8'h01, {7'h00, up_ok});
    $display("test reset done");
    @(posedge clk) i2c <= 1'b1;
    rd_reg(8'hf8, 8'h01);
    chk8("connect allow", 8'h00, {7'h00, up_ok});
    @(posedge clk) i2c <= 1'b0;
    rd_reg(8'hf8, 8'h00);
    chk8("connect allow", 8'h01, {7'h00, up_ok});
    @(posedge clk) smbus <= 1'b1;
    link_op(8'hf8, 8'h00, 3'b001);
    rd_reg(8'hf8, 8'h01);
    link_op(8'hf8, 8'h00, 3'b100);
    rd_reg(8'hf8, 8'h00);
    $display("test mode flag done");
    @(posedge clk);
    ee_addr <= 8'hf0;
    ee_data <= 8'h11;
    ee_wr <= 1'b1;
    @(posedge clk);
    ee_wr <= 1'b0;
    mem[8'hf0] = 8'h11;
    rd_reg(8'hf0, mem[8'hf0]);
    for (int i = 0; i < 16; i++) begin
      v = (i < 8) ? 8'h50 : 8'h90;
      v = v + ((i % 8 < 4) ? i % 8 : 56 + i % 8);
      // odd offsets carry the high half of each code unit
      wr_reg(v, v[0] ? 8'h04 : rnd[7:0]);
      rnd = lfsr(rnd);
      rd_reg(v, mem[v]);
    end
    $display("test text done");
    for (int k = 0; k < 4; k++) begin
      v = (rnd[7:0] & 8'hee) | {3'b000, k[1], 3'b000, k[0]};
      rnd = lfsr(rnd);
      @(posedge clk) lnk <= rnd[3:0];
      wr_reg(8'hf0, v);
      repeat (2) @(posedge clk);
      #1 chk8("indicators", {4'h0, lnk & {4{v[4]}}}, {4'h0, ind});
      chk8("spread disable", {7'h00, v[0]}, {7'h00, spread});
      rd_reg(8'hf0, mem[8'hf0]);
    end
    $display("test feature done");
    desc(8'h03, 7'd3);
    desc(8'h02, 7'd5);
    desc(8'h03, 7'd0);
    desc(8'h05, 7'd4);
    desc(8'h02, 7'd64);
    desc(8'h03, 7'd70);
    $display("test descriptor done");
    wr_reg(8'hf0, 8'h06);
    power(3'h0, 12);
    power(3'h2, 8);
    $display("test power done");
    @(posedge clk) smbus <= 1'b0;
    link_op(8'hf8, 8'h02, 3'b001);
    rd_reg(8'hf0, mem[8'hf0]);
    @(posedge clk) smbus <= 1'b1;
    link_op(8'hf8, 8'h02, 3'b001);
    foreach (mem[i]) mem[i] = 8'h00;
    rd_reg(8'hf8, 8'h01);
    chk8("connect allow", 8'h00, {7'h00, up_ok});
    rd_reg(8'hf0, 8'h00);
    rd_reg(8'h51, 8'h00);
    rd_reg(8'h93, 8'h00);
    wr_reg(8'hf0, 8'h11);
    rd_reg(8'hf0, mem[8'hf0]);
    link_op(8'hf8, 8'h00, 3'b100);
    chk8("connect allow", 8'h01, {7'h00, up_ok});
    $display("test soft reset done");
    complete_run();
  end
endmodule : hub_string_and_smbus_config_regs_bench
